// ==== sim/cafr_can_node.sv ====
// Remote CAN node model that delivers received identifiers.
`timescale 1ns/1ps
module cafr_can_node (
    input wire clk,            // System clock
    output logic msg_valid,    // Identifier strobe
    output logic msg_ext,      // Extended identifier
    output logic [10:0] msg_sid, // Standard bits
    output logic [17:0] msg_eid  // Extended bits
);
    initial begin
        msg_valid = 1'b0;
        {msg_ext, msg_sid, msg_eid} = 30'h0;
    end
    // Between frames the lines carry the inverse, so stale data never hits.
    task send(input logic x, input logic [10:0] s, input logic [17:0] e);
        @(posedge clk);
        msg_valid <= 1'b1;
        {msg_ext, msg_sid, msg_eid} <= {x, s, e};
        @(posedge clk);
        msg_valid <= 1'b0;
        {msg_ext, msg_sid, msg_eid} <= ~{x, s, e};
    endtask
endmodule // cafr_can_node

// ==== sim/cafr_top_sva.sv ====
// Bus and routing assertions for the filter routing block.
`timescale 1ns/1ps
module cafr_top_sva #(
    parameter NUM_FLT = 16, // Number of filters
    parameter NUM_MASK = 4  // Number of masks
) (
    input wire clk,               // Clock
    input wire nrst,              // Reset, active low
    input wire psel,              // APB select
    input wire penable,           // APB enable
    input wire pready,            // APB ready
    input wire [31:0] prdata,     // APB read data
    input wire pslverr,           // APB error
    input wire msg_valid,         // Identifier strobe
    input wire route_valid,       // Decision pulse
    input wire route_hit,         // Accepted
    input wire [4:0] route_fifo,  // Destination
    input wire [3:0] route_filter // Accepting filter
);
    // ====
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    chk_ready_wait: assert property (
        $rose(penable) && psel |-> !pready ##1 pready) else $error("bad wait");
    chk_ready_pulse: assert property (
        pready |=> !pready) else $error("ready too long");
    chk_ready_cause: assert property (
        pready |-> psel && penable && $past(penable)) else $error("stray ready");
    chk_rdata_idle: assert property (
        !pready |-> prdata == 32'h0) else $error("read data leaks");
    chk_err_data: assert property (
        pslverr |-> pready && prdata == 32'h0) else $error("bad error cycle");
    chk_route_lat: assert property (
        msg_valid |=> route_valid) else $error("no decision");
    chk_route_cause: assert property (
        route_valid |-> $past(msg_valid)) else $error("stray decision");
    chk_route_hold: assert property (
        !msg_valid |=> $stable({route_hit, route_fifo, route_filter}))
        else $error("decision moved");
    chk_miss_zero: assert property (
        route_valid && !route_hit |-> route_fifo == 5'h00
        && route_filter == 4'h0) else $error("miss not zero");
endmodule // cafr_top_sva
bind cafr_top cafr_top_sva #(.NUM_FLT(NUM_FLT), .NUM_MASK(NUM_MASK))
u_cafr_top_sva (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .msg_valid(msg_valid), .route_valid(route_valid), .route_hit(route_hit),
    .route_fifo(route_fifo), .route_filter(route_filter));

// ==== sim/tb_cafr_top.sv ====
// Self-checking bench for the filter routing block.
`timescale 1ns/1ps
`include "cafr_defs.vh"
module tb_cafr_top;
    typedef struct packed {
        logic [1:0] r;
        logic [31:0] w;
        logic x;
        logic [10:0] s;
        logic [17:0] e;
        logic [10:0] o;
    } cafr_row_t;
    logic clk, nrst, psel, penable, pwrite, pready, pslverr, er;
    logic msg_valid, msg_ext, route_valid, route_hit;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [10:0] msg_sid;
    logic [17:0] msg_eid;
    logic [4:0] route_fifo;
    logic [3:0] route_filter;
    int bad_count, checks, i;
    logic [31:0] masks [4] = '{32'h0, 32'hffe00000, 32'hffe80000,
        32'hffebffff};
    // Output column is {valid, hit, filter, fifo}.
    cafr_row_t rows [9] = '{
        '{2'd0, 32'h0, 1'b0, 11'd0, 18'h0, 11'h400},
        '{2'd1, 32'ha5, 1'b0, 11'd4, 18'h0, 11'h685},
        '{2'd1, 32'ha5, 1'b0, 11'd5, 18'h0, 11'h400},
        '{2'd3, 32'he1000000, 1'b1, 11'd15, 18'h3ffff, 11'h7e1},
        '{2'd3, 32'he1000000, 1'b1, 11'd15, 18'h3fffe, 11'h400},
        '{2'd3, 32'he1000000, 1'b0, 11'd15, 18'h0, 11'h400},
        '{2'd2, 32'hc9000000, 1'b1, 11'd11, 18'h0, 11'h400},
        '{2'd2, 32'hc9000000, 1'b0, 11'd11, 18'h0, 11'h769},
        '{2'd0, 32'h80, 1'b0, 11'd11, 18'h0, 11'h600}};
    cafr_top u_cafr_top (.clk(clk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .msg_valid(msg_valid), .msg_ext(msg_ext), .msg_sid(msg_sid),
        .msg_eid(msg_eid), .route_valid(route_valid), .route_hit(route_hit),
        .route_fifo(route_fifo), .route_filter(route_filter));
    cafr_can_node u_cafr_can_node (.clk(clk), .msg_valid(msg_valid),
        .msg_ext(msg_ext), .msg_sid(msg_sid), .msg_eid(msg_eid));
    // ====
    // Tasks
    task print_verdict;
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] x);
        checks++;
        if (g !== x) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
        if (n == 20) begin
            bad_count++;
            print_verdict();
        end
    endtask
    // ====
    // Main sequence
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        {nrst, psel, penable, pwrite, paddr, pwdata} = 48'h0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        for (i = 0; i < 4; i++) begin
            apb(1'b0, 12'(4 * i), 32'h0);
            chk(rd, `CAFR_CTRL_RST);
        end
        for (i = 0; i < 4; i++)
            apb(1'b1, `CAFR_OFS_MASK0 + 12'(4 * i), masks[i]);
        for (i = 0; i < 16; i++)
            apb(1'b1, `CAFR_OFS_VALUE0 + 12'(4 * i),
                {11'(i), (i == 15) ? 21'h0bffff : 21'h0});
        for (i = 0; i < 9; i++) begin
            apb(1'b1, 12'(4 * rows[i].r), rows[i].w);
            u_cafr_can_node.send(rows[i].x, rows[i].s, rows[i].e);
            @(posedge clk);
            chk({21'h0, route_valid, route_hit, route_filter, route_fifo},
                {21'h0, rows[i].o});
            apb(1'b0, `CAFR_OFS_STATUS, 32'h0);
            chk(rd, {1'b1, 13'h0, rows[i].o[9], 3'h0, rows[i].o[8:5], 3'h0,
                rows[i].o[4:0], 2'h0});
        end
        for (i = 0; i < 4; i++) begin
            apb(1'b1, 12'(4 * i), 32'h5a3c96f0 + 32'(i));
            apb(1'b0, 12'(4 * i), 32'h0);
            chk(rd, 32'h5a3c96f0 + 32'(i));
        end
        apb(1'b1, `CAFR_OFS_VALUE0, 32'h00200000);
        apb(1'b0, `CAFR_OFS_VALUE0, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, `CAFR_OFS_MASK0, 32'hffffffff);
        apb(1'b0, `CAFR_OFS_MASK0, 32'h0);
        chk(rd, 32'hffebffff);
        apb(1'b0, 12'hffc, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        apb(1'b0, `CAFR_OFS_CTRL3, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, `CAFR_OFS_STATUS, 32'h0);
        chk(rd, 32'h0);
        print_verdict();
    end
endmodule // tb_cafr_top

// ==== src/cafr_defs.vh ====
// Constants for the CAN acceptance filter routing block.
//
// Contract
// - Each filter has one enable bit; zero makes the filter inactive.
// - A 2-bit mask choice selects one of four acceptance masks.
// - A 5-bit destination picks which of 32 FIFOs takes a matching message.
// - Per byte: enable at top, mask choice next two, destination low five.
// - Second control register holds filters 7 down to 4, top to bottom.
// - Third control register holds filters 11 down to 8, top to bottom.
// - Fourth control register holds filters 15 down to 12; sixteen in total.
// - All filter control bits are read/write and reset to zero.
// - Mask identifier bit one compares that bit; zero makes it don't-care.
// - Mask type bit set demands message type equal the filter extended flag.
// - Compared bits must equal filter bits; extended flag picks id type.
`ifndef CAFR_DEFS_VH
`define CAFR_DEFS_VH

// ==================================================================
// Bus geometry
`define CAFR_ADDR_W 12
`define CAFR_NUM_FLT 16
`define CAFR_NUM_MASK 4

// ==================================================================
// Register offsets (byte addresses)
`define CAFR_OFS_CTRL0 12'h000
`define CAFR_OFS_CTRL1 12'h004
`define CAFR_OFS_CTRL2 12'h008
`define CAFR_OFS_CTRL3 12'h00c
`define CAFR_OFS_MASK0 12'h010
`define CAFR_OFS_STATUS 12'h020
`define CAFR_OFS_VALUE0 12'h040

// ==================================================================
// Filter control byte layout
`define CAFR_FLT_ON 7
`define CAFR_MPK_HI 6
`define CAFR_MPK_LO 5
`define CAFR_FTG_HI 4
`define CAFR_FTG_LO 0

// ==================================================================
// Identifier register layout (mask and filter value share it)
`define CAFR_SID_HI 31
`define CAFR_SID_LO 21
`define CAFR_XID_BIT 19
`define CAFR_EID_HI 17
`define CAFR_EID_LO 0
`define CAFR_IDREG_WMASK 32'hffebffff

// ==================================================================
// Reset values
`define CAFR_CTRL_RST 32'h00000000
`define CAFR_IDREG_RST 32'h00000000

`endif

// ==== src/cafr_match.v ====
// One acceptance filter compare against one selected mask.
`timescale 1ns/1ps
`include "cafr_defs.vh"

module cafr_match (
    input wire filt_on,          // Filter enable bit
    input wire [31:0] filt_val,  // Filter identifier value word
    input wire [31:0] mask_val,  // Selected acceptance mask word
    input wire msg_ext,          // Message carries an extended identifier
    input wire [10:0] msg_sid,   // Message standard identifier bits
    input wire [17:0] msg_eid,   // Message extended identifier bits
    output wire hit              // Filter accepts the message
);

// ==================================================================
// Identifier compare
wire [10:0] sid_care;
wire [17:0] eid_care;
wire sid_ok;
wire eid_ok;
wire type_ok;
wire id_type_strict;
wire extended_id_only;

assign sid_care = mask_val[`CAFR_SID_HI:`CAFR_SID_LO];
assign eid_care = mask_val[`CAFR_EID_HI:`CAFR_EID_LO];
assign id_type_strict = mask_val[`CAFR_XID_BIT];
assign extended_id_only = filt_val[`CAFR_XID_BIT];

assign sid_ok = ((msg_sid ^ filt_val[`CAFR_SID_HI:`CAFR_SID_LO])
                & sid_care) == 11'h000;
// Standard frames carry no extended bits, so only extended frames compare
// them; this lets a loose mask accept both frame types.
assign eid_ok = ~msg_ext
                | (((msg_eid ^ filt_val[`CAFR_EID_HI:`CAFR_EID_LO])
                & eid_care) == 18'h00000);
assign type_ok = ~id_type_strict | (msg_ext == extended_id_only);

assign hit = filt_on & sid_ok & eid_ok & type_ok;

endmodule // cafr_match

// ==== src/cafr_top.v ====
// APB register file and routing decision for sixteen acceptance filters.
`timescale 1ns/1ps
`include "cafr_defs.vh"

module cafr_top #(
    parameter NUM_FLT = 16,    // Number of acceptance filters
    parameter NUM_MASK = 4     // Number of acceptance masks
) (
    input wire clk,                       // System clock, 100 MHz
    input wire nrst,                      // Synchronous reset, active low
    input wire psel,                      // APB select
    input wire penable,                   // APB enable
    input wire pwrite,                    // APB direction, high for write
    input wire [`CAFR_ADDR_W-1:0] paddr,  // APB byte address
    input wire [31:0] pwdata,             // APB write data
    output wire pready,                   // APB ready
    output wire [31:0] prdata,            // APB read data
    output wire pslverr,                  // APB error, unmapped address
    input wire msg_valid,                 // Received identifier present
    input wire msg_ext,                   // Identifier is extended
    input wire [10:0] msg_sid,            // Standard identifier bits
    input wire [17:0] msg_eid,            // Extended identifier bits
    output wire route_valid,              // Decision pulse
    output wire route_hit,                // Message accepted
    output wire [4:0] route_fifo,         // Destination FIFO number
    output wire [3:0] route_filter        // Filter that accepted
);

// ==================================================================
// Address classes
localparam CLS_NONE = 5'b00001;
localparam CLS_CTRL = 5'b00010;
localparam CLS_MASK = 5'b00100;
localparam CLS_STAT = 5'b01000;
localparam CLS_VAL = 5'b10000;
localparam [`CAFR_ADDR_W-1:0] OFS_CTRL0 = `CAFR_OFS_CTRL0;
localparam [`CAFR_ADDR_W-1:0] OFS_MASK0 = `CAFR_OFS_MASK0;
localparam [`CAFR_ADDR_W-1:0] OFS_VALUE0 = `CAFR_OFS_VALUE0;

function [4:0] cafr_class;
    input [`CAFR_ADDR_W-1:0] a;
    begin
        if (a[1:0] != 2'h0) begin
            cafr_class = CLS_NONE;
        end else if (a[11:4] == OFS_CTRL0[11:4]) begin
            cafr_class = CLS_CTRL;
        end else if (a[11:4] == OFS_MASK0[11:4]) begin
            cafr_class = CLS_MASK;
        end else if (a == `CAFR_OFS_STATUS) begin
            cafr_class = CLS_STAT;
        end else if (a[11:6] == OFS_VALUE0[11:6]) begin
            cafr_class = CLS_VAL;
        end else begin
            cafr_class = CLS_NONE;
        end
    end
endfunction

// ==================================================================
// Storage
reg [31:0] ctrl_ff [0:3];
reg [31:0] mask_ff [0:NUM_MASK-1];
reg [31:0] fval_ff [0:NUM_FLT-1];
reg pready_ff;
reg [31:0] prdata_ff;
reg pslverr_ff;
reg route_valid_ff;
reg route_hit_ff;
reg [4:0] route_fifo_ff;
reg [3:0] route_filter_ff;
reg seen_ff;

wire acc;
wire wr_now;
wire [4:0] cls;
wire [1:0] ctrl_idx;
wire [1:0] mask_idx;
wire [3:0] val_idx;
wire [NUM_FLT-1:0] flt_hit;
wire [NUM_FLT-1:0] flt_on;
wire [4:0] flt_target [0:NUM_FLT-1];
reg [31:0] rd_val;
reg any_hit;
reg [4:0] nxt_fifo;
reg [3:0] nxt_filter;
integer i;
integer j;
integer k;

assign acc = psel & penable;
assign cls = cafr_class(paddr);
assign ctrl_idx = paddr[3:2];
assign mask_idx = paddr[3:2];
assign val_idx = paddr[5:2];
// The write lands on the edge that completes the access phase.
assign wr_now = acc & pready_ff & pwrite;

// ==================================================================
// Per-filter compare
genvar g;
generate
    for (g = 0; g < NUM_FLT; g = g + 1) begin : gen_flt
        wire [7:0] fbyte;
        wire [1:0] mask_pick;
        wire [31:0] sel_mask;
        // Filter g lives in register g/4, byte g%4, higher byte higher
        // filter.
        assign fbyte = ctrl_ff[g/4][8*(g%4)+7:8*(g%4)];
        assign flt_on[g] = fbyte[`CAFR_FLT_ON];
        assign mask_pick = fbyte[`CAFR_MPK_HI:`CAFR_MPK_LO];
        assign flt_target[g] = fbyte[`CAFR_FTG_HI:`CAFR_FTG_LO];
        assign sel_mask = mask_ff[mask_pick];
        cafr_match u_match (
            .filt_on(flt_on[g]),
            .filt_val(fval_ff[g]),
            .mask_val(sel_mask),
            .msg_ext(msg_ext),
            .msg_sid(msg_sid),
            .msg_eid(msg_eid),
            .hit(flt_hit[g])
        );
    end
endgenerate

// ==================================================================
// Priority select
// Scanning downward lets the lowest matching filter overwrite all others.
always @* begin
    any_hit = 1'b0;
    nxt_fifo = 5'h00;
    nxt_filter = 4'h0;
    for (i = NUM_FLT - 1; i >= 0; i = i - 1) begin
        if (flt_hit[i]) begin
            any_hit = 1'b1;
            nxt_fifo = flt_target[i];
            nxt_filter = i[3:0];
        end
    end
end

// ==================================================================
// Read mux
always @* begin
    rd_val = 32'h00000000;
    case (cls)
        CLS_CTRL: begin
            rd_val = ctrl_ff[ctrl_idx];
        end
        CLS_MASK: begin
            rd_val = mask_ff[mask_idx];
        end
        CLS_STAT: begin
            rd_val = {seen_ff, 13'h0000, route_hit_ff, 3'h0,
                      route_filter_ff, 3'h0, route_fifo_ff, 2'h0};
        end
        CLS_VAL: begin
            rd_val = fval_ff[val_idx];
        end
        default: begin
            rd_val = 32'h00000000;
        end
    endcase
end

// ==================================================================
// APB slave
// One wait state per access: pready rises one cycle into the access
// phase, which keeps the read mux off the critical path.
always @(posedge clk) begin
    if (!nrst) begin
        pready_ff <= 1'b0;
        prdata_ff <= 32'h00000000;
        pslverr_ff <= 1'b0;
    end else begin
        pready_ff <= acc & ~pready_ff;
        if (acc & ~pready_ff) begin
            prdata_ff <= pwrite ? 32'h00000000 : rd_val;
            pslverr_ff <= (cls == CLS_NONE);
        end else begin
            prdata_ff <= 32'h00000000;
            pslverr_ff <= 1'b0;
        end
    end
end

// ==================================================================
// Control and mask registers
always @(posedge clk) begin
    if (!nrst) begin
        for (j = 0; j < 4; j = j + 1) begin
            ctrl_ff[j] <= `CAFR_CTRL_RST;
        end
        for (j = 0; j < NUM_MASK; j = j + 1) begin
            mask_ff[j] <= `CAFR_IDREG_RST;
        end
    end else if (wr_now) begin
        if (cls == CLS_CTRL) begin
            ctrl_ff[ctrl_idx] <= pwdata;
        end
        if (cls == CLS_MASK) begin
            mask_ff[mask_idx] <= pwdata & `CAFR_IDREG_WMASK;
        end
    end
end

// ==================================================================
// Filter value registers
// A write to an enabled filter's value is dropped, so a half-updated
// identifier can never be compared against live traffic.
always @(posedge clk) begin
    if (!nrst) begin
        for (k = 0; k < NUM_FLT; k = k + 1) begin
            fval_ff[k] <= `CAFR_IDREG_RST;
        end
    end else if (wr_now && (cls == CLS_VAL) && !flt_on[val_idx]) begin
        fval_ff[val_idx] <= pwdata & `CAFR_IDREG_WMASK;
    end
end

// ==================================================================
// Routing decision
always @(posedge clk) begin
    if (!nrst) begin
        route_valid_ff <= 1'b0;
        route_hit_ff <= 1'b0;
        route_fifo_ff <= 5'h00;
        route_filter_ff <= 4'h0;
        seen_ff <= 1'b0;
    end else begin
        route_valid_ff <= msg_valid;
        if (msg_valid) begin
            seen_ff <= 1'b1;
            route_hit_ff <= any_hit;
            route_fifo_ff <= any_hit ? nxt_fifo : 5'h00;
            route_filter_ff <= any_hit ? nxt_filter : 4'h0;
        end
    end
end

// ==================================================================
// Outputs
assign pready = pready_ff;
assign prdata = prdata_ff;
assign pslverr = pslverr_ff;
assign route_valid = route_valid_ff;
assign route_hit = route_hit_ff;
assign route_fifo = route_fifo_ff;
assign route_filter = route_filter_ff;

endmodule // cafr_top
